// ---- hdl/pport_map.svh ----
// offsets, field positions, reset values and timing of the parallel port
// assumes an 11-bit byte address on the register port and a 250 MHz mclk_i
//
// Contract
// - status bit 5 reads the live media-empty input.
// - status bit 6 reads the live handshake input.
// - status bit 7 reads the inverted occupied input.
// - control bits 3:0 read back the strobe, autofeed, reset, select-in pin states.
// - in EPP mode hardware drives write and strobes; control writes override. The code ORs the control bits with the hardware strobes.
// - control bit 0 set drives strobe low, clear drives it high.
// - control bit 1 set drives autofeed low, clear drives it high.
// - control bit 2 clear drives peripheral reset low, set drives it high.
// - control bit 3 set drives select-in low, clear drives it high.
// - EPP pins driven only during an EPP cycle, inactive otherwise.
// - control bit 4 enables the handshake interrupt.
// - control bit 5 sets data direction; EPP cycles use access direction.
// - control bits 7:6 always read zero.
// - EPP address port access runs a hardware address cycle.
// - EPP data port access runs a hardware data cycle.
// - EPP ports work only in EPP mode.
// - mode bits 7:5 select output-only, bidirectional or EPP.
// - EPP transfer ends only when wait goes high; data is buffered. The code also ends the cycle when the mode leaves EPP.
// - no wait within timeout aborts the cycle and sets status bit 0.
// - pending bit goes low on handshake rise, high after status read.
// - output-only mode always drives the port data register.
`ifndef PPORT_MAP_SVH
`define PPORT_MAP_SVH
`define OFF_DATA 11'h000
`define OFF_STATUS 11'h001
`define OFF_CONTROL 11'h002
`define OFF_EPP_ADDR 11'h003
`define OFF_EPP_DATA_LO 11'h004
`define OFF_EPP_DATA_HI 11'h007
`define OFF_MODE 11'h402
`define CTL_STROBE 0
`define CTL_AUTOFEED 1
`define CTL_RESET 2
`define CTL_SELECT 3
`define CTL_IRQ_EN 4
`define CTL_DIR 5
`define MODE_LSB 5
`define MODE_OUTPUT_ONLY 3'h0
`define MODE_BIDIR 3'h1
`define MODE_EPP 3'h4
`define CONTROL_RESET 6'h00
`define MODE_REG_RESET 8'h01
`define DATA_RESET 8'h00
`define EPP_TIMEOUT_NS 10000
`define CLK_PERIOD_NS 4
`define EPP_TIMEOUT_CYC ((`EPP_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W 12
`endif

// ---- hdl/pport_pkg.sv ----
// types shared by the parallel port modules
// assumes pport_map.svh for the numbers
package pport_pkg;
  typedef enum logic [1:0] {
    EPP_IDLE = 2'b00,
    EPP_SETUP = 2'b01,
    EPP_STROBE = 2'b11,
    EPP_RELEASE = 2'b10
  } epp_state_e;
  typedef struct packed {
    logic occupied;
    logic handshake_n;
    logic media_empty_input;
    logic select_status;
    logic error_n;
  } periph_in_s;
  typedef struct packed {
    logic select_in_out;
    logic periph_reset_out;
    logic auto_linefeed_out;
    logic data_strobe_out;
  } ctrl_pins_s;
endpackage

// ---- hdl/edge_flag.sv ----
// sticky flag set by a rising edge, cleared by a pulse
// assumes level_i is synchronous to mclk_i
module edge_flag (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic level_i,
  input wire logic clear_i,
  output logic flag_o
);
  logic prev_reg;
  logic flag_reg;
  wire rise = level_i & ~prev_reg;
  // prev resets high so a level already high is no edge
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_reg <= 1'b1;
      flag_reg <= 1'b0;
    end else if (ce_i) begin
      prev_reg <= level_i;
      flag_reg <= rise | (flag_reg & ~clear_i);
    end
  end
  assign flag_o = flag_reg;
endmodule

// ---- hdl/epp_timer.sv ----
// EPP cycle timer: counts while enabled, flags expiry
// assumes en_i drops as soon as the cycle ends or aborts
`include "pport_map.svh"
module epp_timer (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic en_i,
  output logic expired_o
);
  logic [`TIMER_W-1:0] cnt_reg;
  wire last = (cnt_reg == `TIMER_W'(`EPP_TIMEOUT_CYC - 1));
  // held at zero when disabled, so idle outside EPP cycles
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
    end else if (ce_i) begin
      if (!en_i) begin
        cnt_reg <= '0;
      end else if (!last) begin
        cnt_reg <= cnt_reg + `TIMER_W'(1);
      end
    end
  end
  assign expired_o = en_i & last;
endmodule

// ---- hdl/parallel_port_epp_control.sv ----
// parallel port with output-only, bidirectional and EPP modes
// assumes all pin inputs synchronous to mclk_i; the bench resolves the
// data lines from port_data_lines_o and port_data_lines_oe_o
`include "pport_map.svh"
module parallel_port_epp_control (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic [10:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire pport_pkg::periph_in_s periph_i,
  input wire logic [7:0] port_data_lines_i,
  output logic [7:0] port_data_lines_o,
  output logic port_data_lines_oe_o,
  output pport_pkg::ctrl_pins_s pins_o,
  output logic irq_o
);
  import pport_pkg::*;

  function automatic logic is_epp_port(input logic [10:0] a);
    return (a >= `OFF_EPP_ADDR) && (a <= `OFF_EPP_DATA_HI);
  endfunction

  logic [7:0] data_reg;
  logic [5:0] ctrl_reg;
  logic [7:0] mode_reg;
  logic [7:0] wbyte_reg;
  logic [7:0] rbuf_reg;
  logic is_write_reg;
  logic is_addr_reg;
  epp_state_e state_reg;
  epp_state_e state_next;
  ctrl_pins_s pins_next;
  logic [7:0] rdata_next;
  logic [7:0] lines_next;
  logic lines_oe_next;
  logic irq_next;
  logic pending;
  logic timeout_flag;
  logic expired;

  // decode
  wire [2:0] mode = mode_reg[7:`MODE_LSB];
  wire epp_mode = (mode == `MODE_EPP);
  wire out_only = ~epp_mode & (mode != `MODE_BIDIR);
  wire wr_en = ce_i & wr_i;
  wire rd_en = ce_i & rd_i;
  wire wr_data = wr_en & (addr_i == `OFF_DATA);
  wire wr_ctrl = wr_en & (addr_i == `OFF_CONTROL);
  wire wr_mode = wr_en & (addr_i == `OFF_MODE);
  wire status_read = rd_en & (addr_i == `OFF_STATUS);
  wire epp_acc = (wr_i | rd_i) & is_epp_port(addr_i);
  wire idle = (state_reg == EPP_IDLE);
  wire cyc = ~idle;
  wire epp_start = ce_i & epp_mode & idle & epp_acc;
  wire wait_high = periph_i.occupied;
  wire strobing = (state_reg == EPP_STROBE);
  wire write_act = cyc & is_write_reg;
  wire dstb_act = strobing & ~is_addr_reg;
  wire astb_act = strobing & is_addr_reg;

  // timer off outside cycles
  // stopped once wait is seen, so an answer before the last timer cycle never flags a timeout; on that cycle expiry wins
  wire timing = epp_mode & ((state_reg == EPP_SETUP) | strobing);
  epp_timer u_timer (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .en_i(timing),
    .expired_o(expired)
  );

  edge_flag u_pending (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .level_i(periph_i.handshake_n),
    .clear_i(status_read),
    .flag_o(pending)
  );

  edge_flag u_timeout (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .ce_i(ce_i),
    .level_i(expired),
    .clear_i(status_read),
    .flag_o(timeout_flag)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      EPP_IDLE: begin
        if (epp_start) begin
          state_next = EPP_SETUP;
        end
      end
      EPP_SETUP: begin
        state_next = EPP_STROBE;
      end
      EPP_STROBE: begin
        if (expired || !epp_mode) begin
          state_next = EPP_IDLE;
        end else if (wait_high) begin
          state_next = EPP_RELEASE;
        end
      end
      EPP_RELEASE: begin
        state_next = EPP_IDLE;
      end
    endcase
  end

  assign pins_next.data_strobe_out = ~(ctrl_reg[`CTL_STROBE] | (epp_mode & write_act));
  assign pins_next.auto_linefeed_out = ~(ctrl_reg[`CTL_AUTOFEED] | (epp_mode & dstb_act));
  assign pins_next.periph_reset_out = ctrl_reg[`CTL_RESET];
  assign pins_next.select_in_out = ~(ctrl_reg[`CTL_SELECT] | (epp_mode & astb_act));

  assign lines_oe_next = out_only ? 1'b1 : ((epp_mode & cyc) ? is_write_reg : ~ctrl_reg[`CTL_DIR]);
  // a cycle cut short by a mode change must not leak its byte
  assign lines_next = (epp_mode & write_act) ? wbyte_reg : data_reg;
  assign irq_next = ctrl_reg[`CTL_IRQ_EN] & pending;

  wire [7:0] status_val = {
    ~periph_i.occupied,
    periph_i.handshake_n,
    periph_i.media_empty_input,
    periph_i.select_status,
    periph_i.error_n,
    ~pending,
    1'b1,
    epp_mode ? timeout_flag : 1'b1
  };
  wire [7:0] ctrl_val = {
    2'b00,
    ctrl_reg[`CTL_DIR],
    ctrl_reg[`CTL_IRQ_EN],
    ~pins_o.select_in_out,
    pins_o.periph_reset_out,
    ~pins_o.auto_linefeed_out,
    ~pins_o.data_strobe_out
  };
  wire [7:0] epp_val = epp_mode ? rbuf_reg : 8'h00;
  assign rdata_next =
    (addr_i == `OFF_DATA) ? port_data_lines_i :
    (addr_i == `OFF_STATUS) ? status_val :
    (addr_i == `OFF_CONTROL) ? ctrl_val :
    is_epp_port(addr_i) ? epp_val :
    (addr_i == `OFF_MODE) ? mode_reg : 8'h00;

  // software registers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_reg <= `DATA_RESET;
      ctrl_reg <= `CONTROL_RESET;
      mode_reg <= `MODE_REG_RESET;
    end else begin
      if (wr_data) begin
        data_reg <= wdata_i;
      end
      if (wr_ctrl) begin
        ctrl_reg <= wdata_i[5:0];
      end
      if (wr_mode) begin
        mode_reg <= wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= EPP_IDLE;
      wbyte_reg <= 8'h00;
      is_write_reg <= 1'b0;
      is_addr_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      if (epp_start) begin
        wbyte_reg <= wdata_i;
        is_write_reg <= wr_i;
        is_addr_reg <= (addr_i == `OFF_EPP_ADDR);
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rbuf_reg <= 8'h00;
    end else if (ce_i && strobing && wait_high && !is_write_reg && !expired && epp_mode) begin
      rbuf_reg <= port_data_lines_i;
    end
  end

  // outputs all registered
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pins_o <= '{select_in_out: 1'b1, periph_reset_out: 1'b0,
                 auto_linefeed_out: 1'b1, data_strobe_out: 1'b1};
      port_data_lines_o <= 8'h00;
      port_data_lines_oe_o <= 1'b1;
      irq_o <= 1'b0;
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      pins_o <= pins_next;
      port_data_lines_o <= lines_next;
      port_data_lines_oe_o <= lines_oe_next;
      irq_o <= irq_next;
      rdata_o <= rd_i ? rdata_next : 8'h00;
    end
  end

  sequence s_write_setup;
    (state_reg == EPP_SETUP) && is_write_reg && ce_i;
  endsequence

  sequence s_strobe_on;
    strobing && ce_i;
  endsequence

  property p_media_status;
    @(posedge mclk_i) disable iff (!rstn_i)
    status_read |=> rdata_o[5] == $past(periph_i.media_empty_input);
  endproperty
  a_media_status: assert property (p_media_status) else $error("status bit 5 wrong");

  property p_hs_status;
    @(posedge mclk_i) disable iff (!rstn_i)
    status_read |=> rdata_o[6] == $past(periph_i.handshake_n);
  endproperty
  a_hs_status: assert property (p_hs_status) else $error("status bit 6 wrong");

  property p_occ_status;
    @(posedge mclk_i) disable iff (!rstn_i)
    status_read |=> rdata_o[7] != $past(periph_i.occupied);
  endproperty
  a_occ_status: assert property (p_occ_status) else $error("status bit 7 wrong");

  property p_ctrl_readback;
    @(posedge mclk_i) disable iff (!rstn_i)
    (rd_en && addr_i == `OFF_CONTROL) |=>
      rdata_o[2] == $past(pins_o.periph_reset_out) && rdata_o[0] == !$past(pins_o.data_strobe_out);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

  property p_reset_pin;
    @(posedge mclk_i) disable iff (!rstn_i)
    ce_i |=> pins_o.periph_reset_out == $past(ctrl_reg[`CTL_RESET]);
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin not following");

  property p_idle_inactive;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && idle && ctrl_reg[1:0] == 2'b00) |=> pins_o.data_strobe_out && pins_o.auto_linefeed_out;
  endproperty
  a_idle_inactive: assert property (p_idle_inactive) else $error("strobe active outside cycle");

  property p_out_only_drive;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && out_only) |=> port_data_lines_oe_o && port_data_lines_o == $past(data_reg);
  endproperty
  a_out_only_drive: assert property (p_out_only_drive) else $error("output-only not driving");

  property p_ctrl_top_zero;
    @(posedge mclk_i) disable iff (!rstn_i)
    (rd_en && addr_i == `OFF_CONTROL) |=> rdata_o[7:6] == 2'b00;
  endproperty
  a_ctrl_top_zero: assert property (p_ctrl_top_zero) else $error("control bits 7:6 not zero");

  property p_write_order;
    @(posedge mclk_i) disable iff (!rstn_i)
    s_write_setup ##1 s_strobe_on |-> !pins_o.data_strobe_out && port_data_lines_oe_o;
  endproperty
  a_write_order: assert property (p_write_order) else $error("write line late");

  property p_wait_holds;
    @(posedge mclk_i) disable iff (!rstn_i)
    (s_strobe_on and (!wait_high && !expired && epp_mode)) |=> strobing;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("cycle ended without wait");

  property p_timeout_abort;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && expired) |=> idle && timeout_flag;
  endproperty
  a_timeout_abort: assert property (p_timeout_abort) else $error("timeout not taken");

  property p_hs_pending;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && periph_i.handshake_n && !$past(periph_i.handshake_n)) |=> pending;
  endproperty
  a_hs_pending: assert property (p_hs_pending) else $error("pending not set");

  property p_non_epp_ignored;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && !epp_mode && idle) |=> idle;
  endproperty
  a_non_epp_ignored: assert property (p_non_epp_ignored) else $error("EPP cycle outside EPP mode");

  property p_mode_epp;
    @(posedge mclk_i) disable iff (!rstn_i)
    (wr_mode && wdata_i[7:5] == `MODE_EPP) |=> epp_mode;
  endproperty
  a_mode_epp: assert property (p_mode_epp) else $error("EPP mode not selected");

  property p_read_capture;
    @(posedge mclk_i) disable iff (!rstn_i)
    (s_strobe_on and (wait_high && !is_write_reg && !expired && epp_mode)) |=>
      rbuf_reg == $past(port_data_lines_i);
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read byte not buffered");

  property p_cycle_dir;
    @(posedge mclk_i) disable iff (!rstn_i)
    (ce_i && epp_mode && cyc) |=> port_data_lines_oe_o == $past(is_write_reg);
  endproperty
  a_cycle_dir: assert property (p_cycle_dir) else $error("data direction not from access");

  property p_timeout_clear;
    @(posedge mclk_i) disable iff (!rstn_i)
    (status_read && !expired) |=> !timeout_flag;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear) else $error("timeout bit not cleared by read");

endmodule

// ---- verification/periph_model.sv ----
// peripheral on the far side of the parallel port: wait line and read bytes
// assumes the pin struct of pport_pkg and one clock shared with the device
module periph_model (
  input wire logic mclk_i,
  input wire pport_pkg::ctrl_pins_s pins_i,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_i,
  input wire logic respond_i,
  input wire logic idle_lvl_i,
  input wire logic [3:0] delay_i,
  input wire logic [7:0] rd_byte_i,
  output logic wait_o,
  output logic [7:0] lines_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import pport_pkg::*;
  logic strobe_on;
  logic drv;
  logic [7:0] last_q = 8'h00;
  int cnt = 0;
  assign strobe_on = !pins_i.auto_linefeed_out || !pins_i.select_in_out;
  // byte only in a read cycle
  assign drv = strobe_on && pins_i.data_strobe_out && !dev_oe_i;
  // undriven lines flip every cycle so a stale byte never looks valid
  assign lines_o = dev_oe_i ? dev_data_i : (drv ? rd_byte_i : ~last_q);
  assign wait_o = strobe_on ? (respond_i && cnt >= int'(delay_i)) : idle_lvl_i;
  always @(posedge mclk_i) begin
    last_q <= lines_o;
    cnt <= strobe_on ? cnt + 1 : 0;
  end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench of the parallel port: register port, pins and EPP cycles
// assumes periph_model on the far side and the offsets of pport_map.svh
`include "pport_map.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pport_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic ce_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [10:0] addr_i = 11'h000;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o, dout, din;
  logic dout_oe, irq_o, wt;
  ctrl_pins_s pins;
  periph_in_s periph;
  logic hs_n = 1'b1, me = 1'b0, slct = 1'b0, err_n = 1'b1, idle_lvl = 1'b0, respond = 1'b1;
  logic [7:0] rd_byte = 8'h00;
  logic [3:0] dly = 4'h2;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] ctl_m = 8'h00, mode_m = 8'h01;
  logic pend_m = 1'b0, to_m = 1'b0;
  logic [31:0] rnd = 32'hF2F24593;
  logic [7:0] epp_q[$];
  logic [2:0] modes[4] = '{`MODE_OUTPUT_ONLY, `MODE_BIDIR, 3'h2, `MODE_EPP};
  assign periph = {wt, hs_n, me, slct, err_n};
  parallel_port_epp_control parallel_port_epp_control_i (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .periph_i(periph), .port_data_lines_i(din),
    .port_data_lines_o(dout), .port_data_lines_oe_o(dout_oe), .pins_o(pins), .irq_o(irq_o));
  periph_model periph_model_i (
    .mclk_i(mclk_i), .pins_i(pins), .dev_data_i(dout), .dev_oe_i(dout_oe), .respond_i(respond),
    .idle_lvl_i(idle_lvl), .delay_i(dly), .rd_byte_i(rd_byte), .wait_o(wt), .lines_o(din));
  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic nxt();
    repeat (16) rnd = lfsr(rnd);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rdchk(input logic [10:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // status read clears both sticky bits in the model as well
  task automatic rdst();
    rdchk(`OFF_STATUS, {~wt, hs_n, me, slct, err_n, ~pend_m, 1'b1,
      (mode_m[7:5] == `MODE_EPP) ? to_m : 1'b1});
    pend_m = 1'b0;
    to_m = 1'b0;
  endtask
  task automatic watch(input logic w, input logic a, input logic [7:0] b);
    logic seen;
    seen = 1'b0;
    for (int n = 0; n < 60; n++) begin
      @(posedge mclk_i);
      #1;
      if (!seen && (a ? !pins.select_in_out : !pins.auto_linefeed_out)) begin
        seen = 1'b1;
        chk({7'h0, pins.data_strobe_out}, {7'h0, !w});
        chk({7'h0, a ? pins.auto_linefeed_out : pins.select_in_out}, 8'h01);
        chk({7'h0, dout_oe}, {7'h0, w});
        if (w) chk(dout, b);
      end
      if (seen && pins === 4'hF) break;
    end
    chk({7'h0, seen}, 8'h01);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] v, b;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rdchk(`OFF_CONTROL, 8'h00);
    rdchk(`OFF_MODE, `MODE_REG_RESET);
    // edge detector state out of reset is not ours to predict
    rd(`OFF_STATUS, v);
    for (int m = 0; m < 4; m++) begin
      mode_m = {modes[m], 5'h01};
      wr(`OFF_MODE, mode_m);
      rdchk(`OFF_MODE, mode_m);
      repeat (4) begin
        nxt();
        ctl_m = rnd[7:0];
        b = rnd[15:8];
        wr(`OFF_CONTROL, ctl_m);
        wr(`OFF_DATA, b);
        @(posedge mclk_i);
        #1 chk({4'h0, pins}, {4'h0, ~ctl_m[3], ctl_m[2], ~ctl_m[1], ~ctl_m[0]});
        rdchk(`OFF_CONTROL, {2'b00, ctl_m[5:0]});
        chk({7'h0, dout_oe}, {7'h0, m == 0 || m == 2 || !ctl_m[5]});
        if (m == 0 || m == 2) chk(dout, b);
        if (m == 0 || m == 2 || !ctl_m[5]) rdchk(`OFF_DATA, b);
      end
    end
    repeat (8) begin
      nxt();
      ctl_m = {3'b000, rnd[0], 4'h4};
      wr(`OFF_CONTROL, ctl_m);
      if (!hs_n && rnd[1]) pend_m = 1'b1;
      hs_n <= rnd[1];
      me <= rnd[2];
      slct <= rnd[3];
      err_n <= rnd[4];
      idle_lvl <= rnd[5];
      repeat (3) @(posedge mclk_i);
      #1 chk({7'h0, irq_o}, {7'h0, ctl_m[4] & pend_m});
      rdst();
    end
    // frozen clock enable must drop a control write
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(`OFF_CONTROL, 8'h3F);
    ce_i <= 1'b1;
    rdchk(`OFF_CONTROL, ctl_m);
    idle_lvl <= 1'b0;
    ctl_m = 8'h04;
    wr(`OFF_CONTROL, ctl_m);
    @(posedge mclk_i);
    #1 chk({4'h0, pins}, 8'h0F);
    for (int m = 0; m < 10; m++) begin
      nxt();
      dly <= rnd[3:0];
      b = rnd[15:8];
      if (m < 5) begin
        wr(11'(3 + m), b);
      end else begin
        rd_byte <= b;
        rd(11'(3 + m % 5), v);
        chk(v, (m > 5) ? epp_q.pop_front() : 8'h00);
        epp_q.push_back(b);
      end
      watch(m < 5, m % 5 == 0, b);
    end
    rdchk(`OFF_EPP_DATA_LO, epp_q.pop_front());
    watch(1'b0, 1'b0, 8'h00);
    respond <= 1'b0;
    wr(`OFF_EPP_DATA_LO, 8'h5A);
    // still strobing just before the limit, released just after it
    repeat (`EPP_TIMEOUT_CYC - 8) @(posedge mclk_i);
    #1 chk({4'h0, pins}, 8'h0C);
    repeat (16) @(posedge mclk_i);
    #1 chk({4'h0, pins}, 8'h0F);
    to_m = 1'b1;
    rdst();
    rdst();
    respond <= 1'b1;
    mode_m = 8'h01;
    wr(`OFF_MODE, mode_m);
    wr(`OFF_EPP_DATA_LO, 8'h33);
    repeat (8) begin
      @(posedge mclk_i);
      #1 chk({4'h0, pins}, 8'h0F);
    end
    rdchk(`OFF_EPP_ADDR, 8'h00);
    rdchk(11'h010, 8'h00);
    tally_and_finish();
  end
endmodule
